/* File: core/lccr_cfg.svh */
// Purpose: constants of the lane conditioning configuration bank
// Assumes: 8-bit register addresses carried over the two-wire bus
// Notes:   positions are bit numbers within one 8-bit register
// Notes on behaviour
// - Output bits 4:3 hold pre-emphasis, default 0 dB
// - Control enable low: pre-emphasis from strap pin
// - Output bit 2 read/write, 1 means high impedance
// - Input bit 7: 0 is 13 dB, 1 is 9 dB
// - Control enable low: equalization from strap pin
// - Registers 0x11 to 0x1a read-only, any value
// - First write byte is register address, then data
// - Address advances by one per data byte
`ifndef LCCR_CFG_SVH
`define LCCR_CFG_SVH
`define LCCR_OUT_BASE    8'h00
`define LCCR_IN_BASE     8'h08
`define LCCR_VENDOR_A    8'h10
`define LCCR_VENDOR_LO   8'h11
`define LCCR_VENDOR_HI   8'h1a
`define LCCR_PRE_LSB     3
`define LCCR_HIZ_BIT     2
`define LCCR_EQ_BIT      7
`define LCCR_PRE_RESET   2'h0
`define LCCR_HIZ_RESET   1'h0
`define LCCR_EQ_RESET    1'h0
`define LCCR_ADDR_PREFIX 5'h0b
`define LCCR_VENDOR_READ 8'h00
`define LCCR_BYTE_BITS   4'h8
`define LCCR_LAST_RD_BIT 4'h7
`endif

/* File: core/lccr_pkg.sv */
// Purpose: types of the lane conditioning configuration bank
// Assumes: one-hot serial slave states
// Notes:   constants live in lccr_cfg.svh
package lccr_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_ADDR  = 6'h02,
    ST_ACK   = 6'h04,
    ST_WRITE = 6'h08,
    ST_READ  = 6'h10,
    ST_MACK  = 6'h20
  } lccr_state_t;
  typedef enum logic [1:0] {
    PRE_0DB  = 2'h0,
    PRE_3DB  = 2'h1,
    PRE_6DB  = 2'h2,
    PRE_10DB = 2'h3
  } lccr_preemph_t;
endpackage

/* File: core/lccr_top.sv */
// Purpose: eight-lane conditioning settings behind a two-wire slave
// Assumes: clk far faster than the serial clock; pins are asynchronous
// Notes:   open-drain data pin split into in, out and enable
`timescale 1ns/100ps
`include "lccr_cfg.svh"
module lccr_top #(
  parameter logic [7:0] VENDOR_READ_VAL = `LCCR_VENDOR_READ  // Arbitrary
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Two-wire bus
  input  wire logic        i2c_scl,
  input  wire logic        i2c_sda_in,
  output logic             i2c_sda_out,
  output logic             i2c_sda_oe_n,
  // Strap and address pins
  input  wire logic [1:0]  slave_addr_pins,
  input  wire logic        reg_ctrl_en,
  input  wire logic [1:0]  preemph_strap_pin,
  input  wire logic        equalizer_strap_pin,
  // Lane settings
  output logic [15:0]      lane_preemph,
  output logic [7:0]       lane_hiz,
  output logic [7:0]       lane_eq_9db
);
  // Synchroniser stages, reset to bus-idle levels
  logic [7:0]              meta_reg;
  logic [7:0]              sync_reg;
  logic                    scl_d_reg;
  logic                    sda_d_reg;
  lccr_pkg::lccr_state_t   state_reg, state_next;
  logic [3:0]              cnt_reg, cnt_next;
  logic [7:0]              sh_reg, sh_next;
  logic [7:0]              ptr_reg, ptr_next;
  logic                    drv_reg, drv_next;
  logic                    rw_reg, rw_next;
  logic                    first_reg, first_next;
  logic                    mack_reg, mack_next;
  logic [7:0][1:0]         pre_reg;
  logic [7:0]              hiz_reg;
  logic [7:0]              eq_reg;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 8'h03;
      sync_reg <= 8'h03;
    end else begin
      meta_reg <= {slave_addr_pins, preemph_strap_pin,
                   equalizer_strap_pin, reg_ctrl_en, i2c_sda_in, i2c_scl};
      sync_reg <= meta_reg;
    end
  end

  wire       scl_s  = sync_reg[0];
  wire       sda_s  = sync_reg[1];
  wire       en_s   = sync_reg[2];
  wire       eq_s   = sync_reg[3];
  wire [1:0] pre_s  = sync_reg[5:4];
  wire [1:0] addr_s = sync_reg[7:6];

  // Edge and bus condition decode on settled samples
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  wire scl_rise   = scl_s & ~scl_d_reg;
  wire scl_fall   = ~scl_s & scl_d_reg;
  wire start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire addr_match = (sh_reg[7:1] == {`LCCR_ADDR_PREFIX, addr_s});

  // Register address decode
  wire [2:0] lane_idx = ptr_reg[2:0];
  wire out_hit  = (ptr_reg < `LCCR_IN_BASE);
  wire in_hit   = (ptr_reg >= `LCCR_IN_BASE) && (ptr_reg < `LCCR_VENDOR_A);
  wire vendor_hit = (ptr_reg >= `LCCR_VENDOR_A)
                    && (ptr_reg <= `LCCR_VENDOR_HI);
  wire byte_end = scl_fall && (cnt_reg == `LCCR_BYTE_BITS);
  wire in_write = (state_reg == lccr_pkg::ST_WRITE);
  wire ptr_load = in_write && byte_end && first_reg;
  wire wr_strobe = in_write && byte_end && !first_reg;

  // Read data; unused lane bits are forced to zero
  wire [7:0] out_byte = (8'({6'h00, pre_reg[lane_idx]}) << `LCCR_PRE_LSB)
                      | (8'({7'h00, hiz_reg[lane_idx]}) << `LCCR_HIZ_BIT);
  wire [7:0] in_byte  = 8'({7'h00, eq_reg[lane_idx]}) << `LCCR_EQ_BIT;
  wire [7:0] rd_byte  = out_hit  ? out_byte :
                        in_hit   ? in_byte  :
                        vendor_hit ? VENDOR_READ_VAL : 8'h00;

  // Serial slave sequencing; start and stop override any state
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    ptr_next   = ptr_reg;
    drv_next   = drv_reg;
    rw_next    = rw_reg;
    first_next = first_reg;
    mack_next  = mack_reg;
    case (state_reg)
      lccr_pkg::ST_ADDR: begin
        if (scl_rise) begin
          sh_next  = {sh_reg[6:0], sda_s};
          cnt_next = cnt_reg + 4'h1;
        end else if (byte_end) begin
          state_next = addr_match ? lccr_pkg::ST_ACK : lccr_pkg::ST_IDLE;
          drv_next   = addr_match;
          rw_next    = sh_reg[0];
          first_next = 1'b1;
        end
      end
      lccr_pkg::ST_ACK: begin
        if (scl_fall) begin
          cnt_next = 4'h0;
          if (rw_reg) begin
            state_next = lccr_pkg::ST_READ;
            sh_next    = rd_byte;
            drv_next   = ~rd_byte[7];
          end else begin
            state_next = lccr_pkg::ST_WRITE;
            drv_next   = 1'b0;
          end
        end
      end
      lccr_pkg::ST_WRITE: begin
        if (scl_rise) begin
          sh_next  = {sh_reg[6:0], sda_s};
          cnt_next = cnt_reg + 4'h1;
        end else if (byte_end) begin
          state_next = lccr_pkg::ST_ACK;
          drv_next   = 1'b1;
          first_next = 1'b0;
          ptr_next   = first_reg ? sh_reg : ptr_reg + 8'h01;
        end
      end
      lccr_pkg::ST_READ: begin
        if (scl_fall) begin
          if (cnt_reg == `LCCR_LAST_RD_BIT) begin
            state_next = lccr_pkg::ST_MACK;
            drv_next   = 1'b0;
            ptr_next   = ptr_reg + 8'h01;
          end else begin
            sh_next  = {sh_reg[6:0], 1'b0};
            cnt_next = cnt_reg + 4'h1;
            drv_next = ~sh_reg[6];
          end
        end
      end
      lccr_pkg::ST_MACK: begin
        // A not-acknowledge ends the read; wait for stop or start
        if (scl_rise) begin
          mack_next = ~sda_s;
        end else if (scl_fall) begin
          state_next = mack_reg ? lccr_pkg::ST_READ : lccr_pkg::ST_IDLE;
          sh_next    = rd_byte;
          drv_next   = mack_reg & ~rd_byte[7];
          cnt_next   = 4'h0;
        end
      end
      lccr_pkg::ST_IDLE: begin
        drv_next = 1'b0;
      end
      default: begin
        state_next = lccr_pkg::ST_IDLE;
        drv_next   = 1'b0;
      end
    endcase
    if (start_cond) begin
      state_next = lccr_pkg::ST_ADDR;
      cnt_next   = 4'h0;
      drv_next   = 1'b0;
    end else if (stop_cond) begin
      state_next = lccr_pkg::ST_IDLE;
      drv_next   = 1'b0;
    end
  end

  // Sequencer state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= lccr_pkg::ST_IDLE;
      cnt_reg   <= 4'h0;
      sh_reg    <= 8'h00;
      ptr_reg   <= 8'h00;
      drv_reg   <= 1'b0;
      rw_reg    <= 1'b0;
      first_reg <= 1'b0;
      mack_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      ptr_reg   <= ptr_next;
      drv_reg   <= drv_next;
      rw_reg    <= rw_next;
      first_reg <= first_next;
      mack_reg  <= mack_next;
    end
  end

  // Lane control storage; reserved addresses take no write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= {8{`LCCR_PRE_RESET}};
      hiz_reg <= {8{`LCCR_HIZ_RESET}};
      eq_reg  <= {8{`LCCR_EQ_RESET}};
    end else if (wr_strobe && out_hit) begin
      pre_reg[lane_idx] <= sh_reg[`LCCR_PRE_LSB +: 2];
      hiz_reg[lane_idx] <= sh_reg[`LCCR_HIZ_BIT];
    end else if (wr_strobe && in_hit) begin
      eq_reg[lane_idx] <= sh_reg[`LCCR_EQ_BIT];
    end
  end

  // Effective settings; straps win while register control is off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lane_preemph <= 16'h0000;
      lane_hiz     <= 8'h00;
      lane_eq_9db  <= 8'h00;
    end else begin
      lane_preemph <= en_s ? pre_reg : {8{pre_s}};
      lane_hiz     <= hiz_reg;
      lane_eq_9db  <= en_s ? eq_reg : {8{eq_s}};
    end
  end

  // Open drain: only ever pulls low
  assign i2c_sda_out  = 1'b0;
  assign i2c_sda_oe_n = ~drv_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_addr_hit;
    (state_reg == lccr_pkg::ST_ADDR) && byte_end && addr_match
      && !start_cond && !stop_cond;
  endsequence
  sequence s_ack_low;
    !i2c_sda_oe_n;
  endsequence

  a_addr_ack_drive: assert property (s_addr_hit |=> s_ack_low)
    else $error("address match not acknowledged");
  a_ptr_first_byte: assert property (ptr_load && !start_cond && !stop_cond
    |=> ptr_reg == $past(sh_reg))
    else $error("register address not loaded");
  a_ptr_advance: assert property (wr_strobe && !start_cond && !stop_cond
    |=> ptr_reg == $past(ptr_reg) + 8'h01)
    else $error("address did not advance");
  a_vendor_no_write: assert property (wr_strobe && !out_hit && !in_hit
    |=> $stable(pre_reg) && $stable(hiz_reg) && $stable(eq_reg))
    else $error("reserved address changed lane state");
  a_lane_pad_zero: assert property ((out_hit |-> (rd_byte & 8'he3) == 8'h00)
    and (in_hit |-> rd_byte[6:0] == 7'h00))
    else $error("reserved lane bit read nonzero");
  a_pre_strap: assert property (!en_s |=> lane_preemph == {8{$past(pre_s)}})
    else $error("pre-emphasis strap not applied");
  a_pre_reg_path: assert property (en_s ##1 en_s |->
    lane_preemph[15:14] == $past(pre_reg[7]))
    else $error("pre-emphasis register not applied");
  a_eq_strap: assert property (!en_s |=> lane_eq_9db == {8{$past(eq_s)}})
    else $error("equalization strap not applied");
  a_eq_reg_path: assert property (en_s |=> lane_eq_9db == $past(eq_reg))
    else $error("equalization register not applied");
  a_hiz_store: assert property (wr_strobe && out_hit |=>
    hiz_reg[$past(lane_idx)] == $past(sh_reg[`LCCR_HIZ_BIT]) ##1
    lane_hiz == $past(hiz_reg))
    else $error("high impedance bit not stored");
  a_reset_clear: assert property ($rose(arst_n) |->
    pre_reg == 16'h0000 && hiz_reg == 8'h00 && eq_reg == 8'h00)
    else $error("lane registers not cleared by reset");
endmodule

/* File: tb/lccr_master.sv */
// Purpose: behavioural two-wire bus master driving the lane bank
// Assumes: SDA pulled up; half bit lasts H clk cycles
// Notes:   every ack seen and every byte read appears on res_*
`timescale 1ns/100ps
module lccr_master #(
  parameter int H = 8
) (
  // Clock and bus
  input  wire logic       clk,
  input  wire logic       sda,
  output logic            scl,
  output logic            sda_rel,
  // Results
  output logic            res_stb,
  output logic [7:0]      res_val
);
  // Idle bus, both lines high
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
    res_stb = 1'b0;
    res_val = 8'h00;
  end
  task automatic hc(input int n = H);
    repeat (n) @(posedge clk);
  endtask
  // Start or repeated start: SDA falls while SCL high
  task automatic start();
    sda_rel <= 1'b1;
    hc();
    scl <= 1'b1;
    hc();
    sda_rel <= 1'b0;
    hc();
    scl <= 1'b0;
  endtask
  task automatic stop();
    hc(2);
    sda_rel <= 1'b0;
    hc();
    scl <= 1'b1;
    hc();
    sda_rel <= 1'b1;
    hc();
  endtask
  // SDA moves only after SCL fell, so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    hc(2);
    sda_rel <= b;
    hc();
    scl <= 1'b1;
    hc(H / 2);
    s = sda;
    hc(H / 2);
    scl <= 1'b0;
  endtask
  task automatic put(input logic [7:0] v);
    res_val <= v;
    res_stb <= 1'b1;
    @(posedge clk);
    res_stb <= 1'b0;
  endtask
  // Byte out MSB first, then the slave's ack
  task automatic wbyte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    put({7'h00, ~s});
  endtask
  // Byte in; a high ninth bit ends the read
  task automatic rbyte(input logic last);
    logic [7:0] d;
    logic       s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
    put(d);
  endtask
endmodule

/* File: tb/testbench.sv */
// Purpose: self-checking bench of the lane configuration bank
// Assumes: expected values come from a shadow image of the registers
// Notes:   reserved reads are pushed as do-not-care entries
`timescale 1ns/100ps
module testbench;
  logic        clk, arst_n, scl, sda_rel, sda_out, sda_oe_n, en, eq_s;
  logic        res_stb;
  logic [1:0]  ap, pre_s;
  logic [7:0]  res_val, lane_hiz, lane_eq_9db;
  logic [15:0] lane_preemph;
  logic [7:0]  img [16];
  logic [8:0]  exp_q [$];
  logic [8:0]  e;
  int          err_total, total_checks, seed;
  wire logic   sda_in = sda_rel & (sda_oe_n | sda_out);
  lccr_top dut_u (.clk(clk), .arst_n(arst_n), .i2c_scl(scl),
    .i2c_sda_in(sda_in), .i2c_sda_out(sda_out), .i2c_sda_oe_n(sda_oe_n),
    .slave_addr_pins(ap), .reg_ctrl_en(en), .preemph_strap_pin(pre_s),
    .equalizer_strap_pin(eq_s), .lane_preemph(lane_preemph),
    .lane_hiz(lane_hiz), .lane_eq_9db(lane_eq_9db));
  lccr_master m_u (.clk(clk), .sda(sda_in), .scl(scl), .sda_rel(sda_rel),
    .res_stb(res_stb), .res_val(res_val));
  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [15:0] x, input logic [15:0] a);
    total_checks++;
    if (a !== x) begin
      err_total++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, x, a);
    end
  endtask
  // Oldest note meets each result; bit 8 marks do-not-care
  always @(posedge clk) begin
    if (res_stb === 1'b1) begin
      e = exp_q.pop_front();
      if (!e[8]) chk({8'h00, e[7:0]}, {8'h00, res_val});
    end
  end
  function automatic logic [7:0] msk(input int a, input logic [7:0] d);
    return (a < 8) ? (d & 8'h1c) : (d & 8'h80);
  endfunction
  task automatic send(input logic [7:0] d, input logic ack);
    exp_q.push_back({8'h00, ack});
    m_u.wbyte(d);
  endtask
  task automatic wr(input logic [7:0] a, input int n);
    logic [7:0] d;
    m_u.start();
    send({5'h0b, ap, 1'b0}, 1'b1);
    send(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      if (a + i < 16) img[a + i] = msk(a + i, d);
      send(d, 1'b1);
    end
    m_u.stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    m_u.start();
    send({5'h0b, ap, 1'b0}, 1'b1);
    send(a, 1'b1);
    m_u.start();
    send({5'h0b, ap, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back((a + i < 16) ? {1'b0, img[a + i]} : 9'h100);
      m_u.rbyte(i == n - 1);
    end
    m_u.stop();
  endtask
  task automatic lanes();
    logic [15:0] p;
    logic [7:0]  h, q;
    for (int i = 0; i < 8; i++) begin
      p[2*i +: 2] = en ? img[i][4:3] : pre_s;
      h[i] = img[i][2];
      q[i] = en ? img[8 + i][7] : eq_s;
    end
    repeat (6) @(posedge clk);
    chk(p, lane_preemph);
    chk({8'h00, h}, {8'h00, lane_hiz});
    chk({8'h00, q}, {8'h00, lane_eq_9db});
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog, about two and a half times the expected run of 37k cycles
  initial begin
    repeat (90000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    seed = 32'h64173598;
    {arst_n, en, eq_s, ap, pre_s} = 7'h20;
    foreach (img[i]) img[i] = 8'h00;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h00, 16);
    for (int k = 0; k < 4; k++) begin
      ap <= 2'($random(seed));
      @(posedge clk);
      wr(8'h00, 16);
      rd(8'h00, 16);
      lanes();
      en <= 1'b0;
      pre_s <= 2'(k);
      eq_s <= 1'($random(seed));
      @(posedge clk);
      lanes();
      en <= 1'b1;
      @(posedge clk);
    end
    wr(8'h0c, 14);
    rd(8'h0c, 14);
    lanes();
    m_u.start();
    send({5'h0b, ~ap, 1'b0}, 1'b0);
    m_u.stop();
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    foreach (img[i]) img[i] = 8'h00;
    repeat (4) @(posedge clk);
    lanes();
    rd(8'h00, 16);
    report_and_stop();
  end
endmodule
